// ===== hdl/slave_addr_top.sv
// addressing, identity and input image core of the two logical slaves
// ------------------------------------------------------------
// How it works
// - both slaves come out of reset at address zero.
// - second slave stays hidden until the first has nonzero address.
// - address index 0 is slave one, index 1 is slave two.
// - addresses are 0..31 or 33..63; 32 is never valid.
// - in dual mode, writing zero to either address zeroes both and hides slave two.
// - single mode uses index 1 address, limited to 0..31.
// - any stored address change triggers a fieldbus slave reset.
// - single mode reports index 1 id1 code, default 15, 0..15.
// - dual mode id1 codes per slave, default 7, range 0..7.
// - image bits remappable except first slave serial channel bits.
// - slave two default bits: ready, motor active, inputs 1, 2.
// - slave one default bits: inputs 3, 4, serial clock, data.
// - mode 0 is single, 2 is dual; dual is default.
// ------------------------------------------------------------
//
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
module slave_addr_top
(
    input  wire logic        SYS_CLK_IN,
    input  wire logic        RESETN_IN,
    input  wire logic [3:0]  ADDR_IN,
    input  wire logic [15:0] WDATA_IN,
    input  wire logic        WR_IN,
    input  wire logic        RD_IN,
    output logic      [15:0] RDATA_OUT,
    input  wire logic        READY_IN,
    input  wire logic        MOTOR_ACTIVE_IN,
    input  wire logic [3:0]  DIN_IN,
    input  wire logic        SER_CLK_IN,
    input  wire logic        SER_DAT_IN,
    output logic      [slave_addr_pkg::ADDR_W-1:0] ADDR0_OUT,
    output logic      [slave_addr_pkg::ADDR_W-1:0] ADDR1_OUT,
    output logic      [slave_addr_pkg::ID1_W-1:0]  ID1_0_OUT,
    output logic      [slave_addr_pkg::ID1_W-1:0]  ID1_1_OUT,
    output logic                                   DUAL_MODE_OUT,
    output logic                                   SLAVE1_VIS_OUT,
    output logic                                   SLAVE2_VIS_OUT,
    output logic      [slave_addr_pkg::IMG_W-1:0]  IMG1_OUT,
    output logic      [slave_addr_pkg::IMG_W-1:0]  IMG2_OUT,
    output logic                                   SLAVE_RST_OUT
);
    import slave_addr_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [ADDR_W-1:0] addr0_q;
    logic [ADDR_W-1:0] addr1_q;
    logic [ID1_W-1:0]  id10_q;
    logic [ID1_W-1:0]  id11_q;
    logic [1:0]        mode_q;
    logic [11:0]       map2_q;
    logic [11:0]       map1_q;
    logic [2:0]        rst_cnt_q;
    logic              wr_addr0;
    logic              wr_addr1;
    logic              wr_id10;
    logic              wr_id11;
    logic              wr_mode;
    logic              dual;
    logic [ADDR_W-1:0] wa;
    logic [ID1_W-1:0]  wi;
    logic              addr_ok;
    logic              addr_chg;
    logic              id_ok;
    logic              vis2;
    img_if             imgc();

    assign dual = (mode_q == MODE_DUAL);
    assign wa   = WDATA_IN[ADDR_W-1:0];
    assign wi   = WDATA_IN[ID1_W-1:0];

    // ------------------------------------------------------------
    // write checks
    // ------------------------------------------------------------
    always_comb
    begin
        // 32 and anything above 6 bits is refused
        addr_ok = (WDATA_IN[15:ADDR_W] == '0) &&
                  ((wa <= ADDR_A_MAX) ||
                   (dual && wa >= ADDR_B_MIN && wa <= ADDR_B_MAX));
        if (!dual && ADDR_IN == OFF_ADDR0)
        begin
            addr_ok = 1'b0;
        end
        id_ok = (WDATA_IN[15:ID1_W] == '0) &&
                (dual ? (wi <= ID1_DUAL_MAX)
                      : (wi <= ID1_SINGLE_MAX));
        if (!dual && ADDR_IN == OFF_ID10)
        begin
            id_ok = 1'b0;
        end
    end

    assign wr_addr0 = WR_IN && ADDR_IN == OFF_ADDR0 && addr_ok;
    assign wr_addr1 = WR_IN && ADDR_IN == OFF_ADDR1 && addr_ok;
    assign wr_id10  = WR_IN && ADDR_IN == OFF_ID10 && id_ok;
    assign wr_id11  = WR_IN && ADDR_IN == OFF_ID11 && id_ok;
    assign wr_mode  = WR_IN && ADDR_IN == OFF_MODE &&
                      (WDATA_IN == {14'h0000, MODE_SINGLE} ||
                       WDATA_IN == {14'h0000, MODE_DUAL});
    assign addr_chg = (wr_addr0 && wa != addr0_q) ||
                      (wr_addr1 && wa != addr1_q) ||
                      (wr_mode && WDATA_IN[1:0] != mode_q) ||
                      ((wr_mode || ((wr_addr0 || wr_addr1) && wa == '0)) &&
                       {addr0_q, addr1_q} != '0);

    // ------------------------------------------------------------
    // addresses
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            addr0_q <= ADDR_ZERO;
            addr1_q <= ADDR_ZERO;
        end
        else if (wr_mode)
        begin
            // a profile change also drops the addresses
            addr0_q <= ADDR_ZERO;
            addr1_q <= ADDR_ZERO;
        end
        else if ((wr_addr0 || wr_addr1) && wa == ADDR_ZERO)
        begin
            addr0_q <= ADDR_ZERO;
            addr1_q <= ADDR_ZERO;
        end
        else if (wr_addr0)
        begin
            addr0_q <= wa;
        end
        else if (wr_addr1)
        begin
            addr1_q <= wa;
        end
    end

    // ------------------------------------------------------------
    // id1 codes, mode and image maps
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            id10_q <= ID1_DUAL_DEF;
            id11_q <= ID1_DUAL_DEF;
        end
        else if (wr_mode)
        begin
            id10_q <= ID1_DUAL_DEF;
            id11_q <= (WDATA_IN[1:0] == MODE_DUAL) ? ID1_DUAL_DEF
                                                   : ID1_SINGLE_DEF;
        end
        else
        begin
            if (wr_id10)
            begin
                id10_q <= wi;
            end
            if (wr_id11)
            begin
                id11_q <= wi;
            end
        end
    end

    always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            mode_q <= MODE_DUAL;
        end
        else if (wr_mode)
        begin
            mode_q <= WDATA_IN[1:0];
        end
    end

    always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            map2_q <= MAP2_DEF;
            map1_q <= MAP1_DEF;
        end
        else if (WR_IN && ADDR_IN == OFF_MAP2)
        begin
            map2_q <= WDATA_IN[11:0];
        end
        else if (WR_IN && ADDR_IN == OFF_MAP1)
        begin
            // only bits 0 and 1 move; the serial channel has no selector
            map1_q <= {6'h00, WDATA_IN[5:0]};
        end
    end

    // ------------------------------------------------------------
    // slave reset after address change
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            rst_cnt_q <= 3'h0;
        end
        else if (addr_chg)
        begin
            rst_cnt_q <= 3'(RST_CYCLES);
        end
        else if (rst_cnt_q != 3'h0)
        begin
            rst_cnt_q <= rst_cnt_q - 3'h1;
        end
    end

    // ------------------------------------------------------------
    // image sources
    // ------------------------------------------------------------
    assign imgc.map2    = map2_q;
    assign imgc.map1    = map1_q;
    assign imgc.src     = {2'b00, DIN_IN, MOTOR_ACTIVE_IN, READY_IN};
    assign imgc.ser_clk = SER_CLK_IN;
    assign imgc.ser_dat = SER_DAT_IN;

    img_mapper u_map
    (
        .m (imgc.mapper)
    );

    // slave two needs a dual profile and an addressed slave one
    assign vis2 = dual && addr0_q != ADDR_ZERO;

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            ADDR0_OUT      <= ADDR_ZERO;
            ADDR1_OUT      <= ADDR_ZERO;
            ID1_0_OUT      <= ID1_DUAL_DEF;
            ID1_1_OUT      <= ID1_DUAL_DEF;
            DUAL_MODE_OUT  <= 1'b1;
            SLAVE1_VIS_OUT <= 1'b0;
            SLAVE2_VIS_OUT <= 1'b0;
            IMG1_OUT       <= 4'h0;
            IMG2_OUT       <= 4'h0;
            SLAVE_RST_OUT  <= 1'b1;
        end
        else
        begin
            ADDR0_OUT      <= addr0_q;
            ADDR1_OUT      <= addr1_q;
            ID1_0_OUT      <= id10_q;
            ID1_1_OUT      <= id11_q;
            DUAL_MODE_OUT  <= dual;
            SLAVE1_VIS_OUT <= dual && rst_cnt_q == 3'h0;
            SLAVE2_VIS_OUT <= vis2 && rst_cnt_q == 3'h0;
            IMG1_OUT       <= imgc.img1;
            IMG2_OUT       <= imgc.img2;
            SLAVE_RST_OUT  <= rst_cnt_q != 3'h0;
        end
    end

    // ------------------------------------------------------------
    // register read
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            RDATA_OUT <= 16'h0000;
        end
        else if (RD_IN)
        begin
            unique case (ADDR_IN)
                OFF_ADDR0: RDATA_OUT <= {10'h000, addr0_q};
                OFF_ADDR1: RDATA_OUT <= {10'h000, addr1_q};
                OFF_ID10:  RDATA_OUT <= {12'h000, id10_q};
                OFF_ID11:  RDATA_OUT <= {12'h000, id11_q};
                OFF_MODE:  RDATA_OUT <= {14'h0000, mode_q};
                OFF_MAP2:  RDATA_OUT <= {4'h0, map2_q};
                OFF_MAP1:  RDATA_OUT <= {4'h0, map1_q};
                OFF_STAT:  RDATA_OUT <= {13'h0000, vis2,
                                         rst_cnt_q != 3'h0, dual};
                default:   RDATA_OUT <= 16'h0000;
            endcase
        end
        else
        begin
            RDATA_OUT <= 16'h0000;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_hide2;
        @(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
        addr0_q == ADDR_ZERO |=> !SLAVE2_VIS_OUT;
    endproperty
    a_hide2: assert property (p_hide2)
        else $error("slave two visible while slave one unaddressed");

    property p_no32;
        @(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
        addr0_q != 6'h20 && addr1_q != 6'h20;
    endproperty
    a_no32: assert property (p_no32)
        else $error("address 32 stored");

    property p_zero_both;
        @(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
        (wr_addr0 || wr_addr1) && wa == ADDR_ZERO
        |=> addr0_q == ADDR_ZERO && addr1_q == ADDR_ZERO;
    endproperty
    a_zero_both: assert property (p_zero_both)
        else $error("zero write did not clear both addresses");

    property p_single_a;
        @(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
        !dual && !$past(wr_mode) |-> addr1_q <= ADDR_A_MAX;
    endproperty
    a_single_a: assert property (p_single_a)
        else $error("single mode address outside A range");

    property p_rst;
        @(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
        addr_chg |=> ##1 SLAVE_RST_OUT [*4] ##1 !SLAVE_RST_OUT;
    endproperty
    a_rst: assert property (p_rst)
        else $error("slave reset pulse wrong after address change");

    property p_id_dual;
        @(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
        dual |-> id10_q <= ID1_DUAL_MAX && id11_q <= ID1_DUAL_MAX;
    endproperty
    a_id_dual: assert property (p_id_dual)
        else $error("dual id1 code above 7");

    property p_ser;
        @(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
        1'b1 |=> IMG1_OUT[3:2] == $past({SER_DAT_IN, SER_CLK_IN});
    endproperty
    a_ser: assert property (p_ser)
        else $error("serial channel bits not passed through");
    property p_keep;
        @(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
        WR_IN && ADDR_IN == OFF_ID11 && !id_ok && !wr_mode
        |=> $stable(id11_q);
    endproperty
    a_keep: assert property (p_keep)
        else $error("refused id1 write changed the stored code");
    c_vis2: cover property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
        $rose(SLAVE2_VIS_OUT));
    c_zero: cover property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
        $fell(SLAVE2_VIS_OUT));
    c_single: cover property (@(posedge SYS_CLK_IN)
        disable iff (!RESETN_IN) $fell(DUAL_MODE_OUT));
endmodule

// ===== hdl/slave_addr_pkg.sv
// shared constants for the dual fieldbus slave addressing block
package slave_addr_pkg;
    localparam int ADDR_W = 6;
    localparam int ID1_W  = 4;
    localparam int IMG_W  = 4;

    // register offsets
    localparam logic [3:0] OFF_ADDR0 = 4'h0;
    localparam logic [3:0] OFF_ADDR1 = 4'h1;
    localparam logic [3:0] OFF_ID10  = 4'h2;
    localparam logic [3:0] OFF_ID11  = 4'h3;
    localparam logic [3:0] OFF_MODE  = 4'h4;
    localparam logic [3:0] OFF_MAP2  = 4'h5;
    localparam logic [3:0] OFF_MAP1  = 4'h6;
    localparam logic [3:0] OFF_STAT  = 4'h7;

    // address ranges
    localparam logic [5:0] ADDR_ZERO  = 6'h00;
    localparam logic [5:0] ADDR_A_MAX = 6'h1F;
    localparam logic [5:0] ADDR_B_MIN = 6'h21;
    localparam logic [5:0] ADDR_B_MAX = 6'h3F;

    // mode codes
    localparam logic [1:0] MODE_SINGLE = 2'h0;
    localparam logic [1:0] MODE_DUAL   = 2'h2;

    // id1 defaults and limits
    localparam logic [3:0] ID1_SINGLE_DEF = 4'hF;
    localparam logic [3:0] ID1_SINGLE_MAX = 4'hF;
    localparam logic [3:0] ID1_DUAL_DEF   = 4'h7;
    localparam logic [3:0] ID1_DUAL_MAX   = 4'h7;

    // signal sources for image bits: 0..5 local signals, 6..7 tied low
    localparam logic [2:0] SRC_READY  = 3'h0;
    localparam logic [2:0] SRC_MOTOR  = 3'h1;
    localparam logic [2:0] SRC_DIN1   = 3'h2;
    localparam logic [2:0] SRC_DIN2   = 3'h3;
    localparam logic [2:0] SRC_DIN3   = 3'h4;
    localparam logic [2:0] SRC_DIN4   = 3'h5;
    localparam logic [11:0] MAP2_DEF  = 12'h6_88;
    localparam logic [11:0] MAP1_DEF  = 12'h0_2C;

    // slave reset pulse length in cycles
    localparam int RST_CYCLES = 4;
endpackage

// ===== hdl/img_if.sv
// carrier between the core and the image mapper
`timescale 1ns/1ps
interface img_if;
    logic [11:0] map2;
    logic [11:0] map1;
    logic [7:0]  src;
    logic        ser_clk;
    logic        ser_dat;
    logic [3:0]  img2;
    logic [3:0]  img1;
    modport core   (output map2, map1, src, ser_clk, ser_dat,
                    input img2, img1);
    modport mapper (input map2, map1, src, ser_clk, ser_dat,
                    output img2, img1);
endinterface

// ===== hdl/img_mapper.sv
// signal interconnection of the slave-to-master input images
`timescale 1ns/1ps
module img_mapper
(
    img_if.mapper m
);
    import slave_addr_pkg::*;
    // ------------------------------------------------------------
    // selectors
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < IMG_W; i++)
        begin : g_bit
            assign m.img2[i] = m.src[m.map2[3*i +: 3]];
        end
        for (i = 0; i < 2; i++)
        begin : g_bit1
            assign m.img1[i] = m.src[m.map1[3*i +: 3]];
        end
    endgenerate
    // serial channel stays fixed regardless of the map
    assign m.img1[2] = m.ser_clk;
    assign m.img1[3] = m.ser_dat;
endmodule

// ===== sim/asi_master_model.sv
// far-side fieldbus master model for the slave addressing bench
`timescale 1ns/1ps
module asi_master_model
#(
    parameter logic [5:0] FIRST_ADDR = 6'h05
)
(
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       vis1_in,
    input  wire logic       vis2_in,
    input  wire logic [5:0] addr0_in,
    input  wire logic [5:0] addr1_in,
    output logic            auto_ok_out,
    output logic            reprog_ok_out,
    output logic [5:0]      pick_out
);
    logic [1:0] zero_cnt;
    logic       had_both_q;
    // ----------------------------------------
    // auto addressing decision
    // ----------------------------------------
    assign zero_cnt = 2'(vis1_in && addr0_in == 6'h00)
                    + 2'(vis2_in && addr1_in == 6'h00);
    // several slaves at zero: auto addressing stops
    assign auto_ok_out = (zero_cnt == 2'h1);
    // picks stay distinct and nonzero
    assign pick_out = vis2_in ? FIRST_ADDR + 6'h01 : FIRST_ADDR;
    // ----------------------------------------
    // lost units: two missing addresses stop reprogramming
    // ----------------------------------------
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            had_both_q    <= 1'b0;
            reprog_ok_out <= 1'b1;
        end
        else
        begin
            had_both_q <= (addr0_in != 6'h00) && (addr1_in != 6'h00);
            if (had_both_q && addr0_in == 6'h00 && addr1_in == 6'h00)
                reprog_ok_out <= 1'b0;
        end
    end
endmodule

// ===== sim/dual_fieldbus_slave_addressing_tb.sv
// self-checking bench for the dual fieldbus slave addressing block
`timescale 1ns/1ps
module dual_fieldbus_slave_addressing_tb;
    import slave_addr_pkg::*;
    logic        clk;
    logic        rst_n;
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
    logic [15:0] rdata;
    logic        ready;
    logic        motor;
    logic        ser_clk;
    logic        ser_dat;
    logic [3:0]  din;
    logic [5:0]  a0;
    logic [5:0]  a1;
    logic [3:0]  i0;
    logic [3:0]  i1;
    logic        dual;
    logic        vis1;
    logic        vis2;
    logic        srst;
    logic [3:0]  img1;
    logic [3:0]  img2;
    logic        auto_ok;
    logic        reprog_ok;
    logic [5:0]  pick;
    int          n_errors;
    int          total_checks;

    slave_addr_top uut
    (
        .SYS_CLK_IN      (clk),
        .RESETN_IN       (rst_n),
        .ADDR_IN         (addr),
        .WDATA_IN        (wdata),
        .WR_IN           (wr),
        .RD_IN           (rd),
        .RDATA_OUT       (rdata),
        .READY_IN        (ready),
        .MOTOR_ACTIVE_IN (motor),
        .DIN_IN          (din),
        .SER_CLK_IN      (ser_clk),
        .SER_DAT_IN      (ser_dat),
        .ADDR0_OUT       (a0),
        .ADDR1_OUT       (a1),
        .ID1_0_OUT       (i0),
        .ID1_1_OUT       (i1),
        .DUAL_MODE_OUT   (dual),
        .SLAVE1_VIS_OUT  (vis1),
        .SLAVE2_VIS_OUT  (vis2),
        .IMG1_OUT        (img1),
        .IMG2_OUT        (img2),
        .SLAVE_RST_OUT   (srst)
    );

    asi_master_model #(.FIRST_ADDR(6'h05)) master
    (
        .clk_in        (clk),
        .rst_n_in      (rst_n),
        .vis1_in       (vis1),
        .vis2_in       (vis2),
        .addr0_in      (a0),
        .addr1_in      (a1),
        .auto_ok_out   (auto_ok),
        .reprog_ok_out (reprog_ok),
        .pick_out      (pick)
    );

    always #2.5 clk = ~clk;

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic finish_test;
        $display("checks=%0d errors=%0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask

    // slave reset must stand exactly its documented length
    task automatic wr_pulse(input logic [3:0] a, input logic [15:0] d);
        int n;
        n = 0;
        wr_reg(a, d);
        @(posedge clk);
        #1;
        while (srst === 1'b1 && n < 20)
        begin
            n++;
            @(posedge clk);
            #1;
        end
        chk(16'(n), 16'(RST_CYCLES));
        if (n == 20)
            finish_test();
    endtask

    // refused write leaves the stored value in place
    task automatic rej(input logic [3:0] a, input logic [15:0] d,
                       input logic [15:0] keep);
        wr_reg(a, d);
        rd_chk(a, keep);
    endtask

    task automatic power_cycle;
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic img_step(input logic [7:0] v, input logic remap);
        logic [3:0] e1;
        logic [3:0] e2;
        @(posedge clk);
        din     <= v[3:0];
        ready   <= v[4];
        motor   <= v[5];
        ser_clk <= v[6];
        ser_dat <= v[7];
        e2 = {v[1], v[0], v[5], remap ? v[3] : v[4]};
        e1 = {v[7], v[6], remap ? {v[4], v[4]} : v[3:2]};
        repeat (2) @(posedge clk);
        #1;
        chk(16'({img2, img1}), 16'({e2, e1}));
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_defaults;
        chk(16'({a0, a1}), 16'h0000);
        chk(16'({vis1, vis2, dual}), 16'h0005);
        chk(16'({i0, i1}), 16'h0077);
        chk(16'(auto_ok), 16'h0001);
        rd_chk(OFF_MODE, 16'h0002);
        rd_chk(OFF_STAT, 16'h0001);
        rd_chk(4'h8, 16'h0000);
        $display("test defaults done");
    endtask

    task automatic t_auto;
        wr_pulse(OFF_ADDR0, 16'(pick));
        wr_pulse(OFF_ADDR1, 16'h0000);
        chk(16'({a0, vis2}), 16'h0000);
        wr_pulse(OFF_ADDR0, 16'(pick));
        chk(16'({a0, vis2}), 16'h000B);
        chk(16'(auto_ok), 16'h0001);
        wr_pulse(OFF_ADDR1, 16'(pick));
        rd_chk(OFF_ADDR0, 16'h0005);
        rd_chk(OFF_ADDR1, 16'h0006);
        rd_chk(OFF_STAT, 16'h0005);
        wr_pulse(OFF_ADDR1, 16'h0021);
        wr_pulse(OFF_ADDR0, 16'h003F);
        chk(16'({a0, a1}), 16'h0FE1);
        $display("test auto addressing done");
    endtask

    task automatic t_range;
        rej(OFF_ADDR0, 16'h0020, 16'h003F);
        rej(OFF_ADDR0, 16'h0040, 16'h003F);
        rej(OFF_ADDR1, 16'h8005, 16'h0021);
        rej(OFF_ID10, 16'h0008, 16'h0007);
        wr_reg(OFF_ID10, 16'h0003);
        rd_chk(OFF_ID10, 16'h0003);
        chk(16'({i0, i1, srst}), 16'h006E);
        $display("test ranges done");
    endtask

    task automatic t_zero;
        wr_pulse(OFF_ADDR1, 16'h0000);
        chk(16'({a0, a1, vis2}), 16'h0000);
        chk(16'(reprog_ok), 16'h0000);
        power_cycle();
        chk(16'({auto_ok, vis2}), 16'h0002);
        $display("test zeroing done");
    endtask

    task automatic t_single;
        wr_pulse(OFF_MODE, 16'h0000);
        chk(16'({dual, vis1, vis2, i1}), 16'h000F);
        rej(OFF_ID11, 16'h0010, 16'h000F);
        rej(OFF_ADDR1, 16'h0021, 16'h0000);
        rej(OFF_ADDR0, 16'h0005, 16'h0000);
        wr_pulse(OFF_ADDR1, 16'h001F);
        chk(16'(a1), 16'h001F);
        rej(OFF_MODE, 16'h0001, 16'h0000);
        wr_pulse(OFF_MODE, 16'h0000);
        chk(16'(a1), 16'h0000);
        wr_pulse(OFF_MODE, 16'h0002);
        chk(16'({dual, a1, i0, i1}), 16'h4077);
        $display("test single mode done");
    endtask

    task automatic t_image;
        rd_chk(OFF_MAP2, 16'h0688);
        rd_chk(OFF_MAP1, 16'h002C);
        img_step(8'h56, 1'b0);
        img_step(8'hA9, 1'b0);
        wr_reg(OFF_MAP2, 16'h068D);
        wr_reg(OFF_MAP1, 16'h0000);
        img_step(8'h56, 1'b1);
        img_step(8'hA9, 1'b1);
        $display("test images done");
    endtask

    initial
    begin
        clk = 1'b0;
        rst_n = 1'b0;
        addr = 4'h0;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
        ready = 1'b0;
        motor = 1'b0;
        ser_clk = 1'b0;
        ser_dat = 1'b0;
        din = 4'h0;
        n_errors = 0;
        total_checks = 0;
        power_cycle();
        t_defaults();
        t_auto();
        t_range();
        t_zero();
        t_single();
        t_image();
        finish_test();
    end
endmodule
